// ==== hdl/fcsm_pkg.sv ====
package fcsm_pkg;

	// ==========================================
	// flash pin widths
	localparam int AW = 20;
	localparam int DW = 16;

	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_WDATA  = 8'h08;
	localparam logic [7:0] REG_RDATA  = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_CFG    = 8'h14;
	localparam logic [2:0] CFG_RST    = 3'h0;
	localparam int         CFG_BYTE   = 0;
	localparam int         CFG_HV     = 1;
	localparam int         CFG_HWRST  = 2;
	localparam int         TMO_BIT    = 5;

	// ==========================================
	// operations
	localparam logic [2:0] OP_READ    = 3'h0;
	localparam logic [2:0] OP_RESET   = 3'h1;
	localparam logic [2:0] OP_AUTOSEL = 3'h2;
	localparam logic [2:0] OP_PROG    = 3'h3;
	localparam logic [2:0] OP_CERASE  = 3'h4;

	// ==========================================
	// default unlock addresses (word mode) and codes
	localparam logic [19:0] UA1_W     = 20'h00555;
	localparam logic [19:0] UA2_W     = 20'h002AA;
	localparam logic [15:0] C_UNLK1   = 16'h00AA;
	localparam logic [15:0] C_UNLK2   = 16'h0055;
	localparam logic [15:0] C_AUTOSEL = 16'h0090;
	localparam logic [15:0] C_RESET   = 16'h00F0;
	localparam logic [15:0] C_PROG    = 16'h00A0;
	localparam logic [15:0] C_ESETUP  = 16'h0080;
	localparam logic [15:0] C_CERASE  = 16'h0010;

	// ==========================================
	// timing
	localparam int CLK_MHZ   = 40;
	localparam int T_SU_NS   = 30;
	localparam int T_WP_NS   = 45;
	localparam int T_ACC_NS  = 100;
	localparam int T_REC_NS  = 30;
	localparam int T_BUSY_NS = 100;
	localparam logic [4:0] SYNC_LAT = 5'h4;
	localparam logic [4:0] CY_SU   = 5'((T_SU_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] CY_WP   = 5'((T_WP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] CY_ACC  = 5'((T_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] CY_REC  = 5'((T_REC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [4:0] CY_BUSY = 5'((T_BUSY_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [3:0] {
		S_IDLE   = 4'b0001,
		S_SETUP  = 4'b0010,
		S_STROBE = 4'b0100,
		S_RECOV  = 4'b1000
	} fcsm_state_t;

endpackage : fcsm_pkg

// ==== hdl/fcsm_host.sv ====
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - write only with chip select and write strobe low, output enable high
// - autoselect is left by a reset command or by the hardware reset bit from software
// - timeout flag seen in read data lets software issue reset
// - autoselect is two unlocks, the command, then one read
// - program is two unlocks, set-up, then address and data
// - chip erase is two unlocks, set-up, two unlocks, erase command
module fcsm_host #(
	parameter logic [19:0] P_UA1      = fcsm_pkg::UA1_W,
	parameter logic [19:0] P_UA2      = fcsm_pkg::UA2_W,
	parameter logic [15:0] P_UNLK1    = fcsm_pkg::C_UNLK1,
	parameter logic [15:0] P_UNLK2    = fcsm_pkg::C_UNLK2,
	parameter logic [15:0] P_AUTOSEL  = fcsm_pkg::C_AUTOSEL,
	parameter logic [15:0] P_RESET    = fcsm_pkg::C_RESET,
	parameter logic [15:0] P_PROG     = fcsm_pkg::C_PROG,
	parameter logic [15:0] P_ESETUP   = fcsm_pkg::C_ESETUP,
	parameter logic [15:0] P_CERASE   = fcsm_pkg::C_CERASE
) (
	// clock and reset
	input  wire logic                      CLK_SYS,
	input  wire logic                      RST,
	// wishbone slave
	input  wire logic                      CYC_I,
	input  wire logic                      STB_I,
	input  wire logic                      WE_I,
	input  wire logic [7:0]                ADR_I,
	input  wire logic [3:0]                SEL_I,
	input  wire logic [31:0]               DAT_I,
	output logic      [31:0]               DAT_O,
	output logic                           ACK_O,
	// flash pins
	output logic      [fcsm_pkg::AW-1:0]   FL_ADDR,
	input  wire logic [fcsm_pkg::DW-1:0]   FL_DQ_I,
	output logic      [fcsm_pkg::DW-1:0]   FL_DQ_O,
	output logic                           FL_DQ_OE,
	output logic                           FL_CE_N,
	output logic                           FL_OE_N,
	output logic                           FL_WE_N,
	output logic                           FL_BYTE_N,
	output logic                           FL_RESET_N,
	output logic                           FL_HV_EN,
	input  wire logic                      FL_READY_BUSY_N,
	// supply monitor
	input  wire logic                      VCC_OK
);
	import fcsm_pkg::*;

	// ==========================================
	// input synchronisers
	localparam int NS = DW + 2;
	// supply and ready pins share the data filter so all inputs lag alike

	logic [NS-1:0] s1_q;
	logic [NS-1:0] s2_q;
	logic [NS-1:0] s3_q;
	logic [NS-1:0] filt_q;
	wire  [NS-1:0] raw = {VCC_OK, FL_READY_BUSY_N, FL_DQ_I};

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit changes only once two late stages agree, filtering bus glitches
	for (genvar g = 0; g < NS; g++) begin : g_filt
		always_ff @(posedge CLK_SYS or posedge RST) begin
			if (RST) begin
				filt_q[g] <= 1'b0;
			end else if (s2_q[g] == s3_q[g]) begin
				filt_q[g] <= s3_q[g];
			end
		end
	end

	wire [DW-1:0] dq_f   = filt_q[DW-1:0];
	wire          ready_f = filt_q[DW];
	wire          vcc_f   = filt_q[DW+1];

	// ==========================================
	// sequence table
	function automatic logic [35:0] fcsm_step(input logic [2:0] op, input logic [2:0] i,
		input logic bm, input logic [19:0] ua, input logic [15:0] ud);
		logic [19:0] a1;
		logic [19:0] a2;
		logic [15:0] c3;
		// byte mode doubles the unlock addresses; data stays in the low byte
		a1 = bm ? {P_UA1[18:0], 1'b0} : P_UA1;
		a2 = bm ? {P_UA2[18:0], 1'b0} : P_UA2;
		c3 = (op == OP_PROG) ? P_PROG : (op == OP_CERASE) ? P_ESETUP : P_AUTOSEL;
		case (i)
			3'h0: fcsm_step = (op == OP_RESET) ? {ua, P_RESET} : {a1, P_UNLK1};
			3'h1: fcsm_step = {a2, P_UNLK2};
			3'h2: fcsm_step = {a1, c3};
			3'h3: fcsm_step = (op == OP_PROG) ? {ua, ud} : {a1, P_UNLK1};
			3'h4: fcsm_step = {a2, P_UNLK2};
			default: fcsm_step = {a1, P_CERASE};
		endcase
	endfunction : fcsm_step

	// ==========================================
	// registers and bus decode
	logic [2:0]    op_q;
	logic [AW-1:0] ua_q;
	logic [DW-1:0] ud_q;
	logic [DW-1:0] rd_q;
	logic [2:0]    cfg_q;
	logic          refused_q;
	logic          ack_q;
	logic [31:0]   dat_q;
	fcsm_state_t   st_q;
	logic [2:0]    idx_q;
	logic [4:0]    cnt_q;

	// ack_q masks the request so one strobe yields one acknowledge
	wire        bus_req = CYC_I & STB_I & ~ack_q;
	wire        wr      = bus_req & WE_I & SEL_I[0];
	wire        hit_cmd = ADR_I == REG_CMD;
	wire        hit_adr = ADR_I == REG_ADDR;
	wire        hit_wd  = ADR_I == REG_WDATA;
	wire        hit_cfg = ADR_I == REG_CFG;
	wire [31:0] w_wd    = {16'h0000, ud_q};
	// status shows the filtered pins, as the sequencer sees them
	wire [31:0] w_sts   = {26'h0000000, cfg_q[CFG_HV], rd_q[TMO_BIT], refused_q,
	                       vcc_f, ~ready_f, st_q != S_IDLE};
	wire [31:0] rd_mux  = hit_cmd ? {29'h00000000, op_q} :
	                      hit_adr ? {12'h000, ua_q} :
	                      hit_wd  ? w_wd :
	                      (ADR_I == REG_RDATA)  ? {16'h0000, rd_q} :
	                      (ADR_I == REG_STATUS) ? w_sts :
	                      hit_cfg ? {29'h00000000, cfg_q} : 32'h00000000;

	wire can_go = (st_q == S_IDLE) & vcc_f & ~cfg_q[CFG_HWRST];
	wire start  = wr & hit_cmd & can_go;

	// ==========================================
	// sequencer decode
	wire [2:0] nw = (op_q == OP_RESET) ? 3'h1 :
	                (op_q == OP_AUTOSEL) ? 3'h3 :
	                (op_q == OP_PROG) ? 3'h4 :
	                (op_q == OP_CERASE) ? 3'h6 : 3'h0;
	wire       has_rd  = (op_q == OP_READ) | (op_q == OP_AUTOSEL);
	wire       dev_alg = (op_q == OP_PROG) | (op_q == OP_CERASE);
	// the read, if any, follows every write of the sequence
	wire       step_rd = idx_q == nw;
	wire       last    = idx_q == (nw - {2'b00, ~has_rd});
	wire       done    = cnt_q == 5'h00;
	wire [35:0] cur    = fcsm_step(op_q, idx_q, cfg_q[CFG_BYTE], ua_q, ud_q);

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= bus_req;
			dat_q <= (bus_req & ~WE_I) ? rd_mux : dat_q;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ua_q <= '0;
			ud_q <= '0;
			cfg_q <= CFG_RST;
			refused_q <= 1'b0;
		end else begin
			if (wr & hit_adr & SEL_I[1] & SEL_I[2]) ua_q <= DAT_I[AW-1:0];
			if (wr & hit_wd & SEL_I[1]) ud_q <= DAT_I[DW-1:0];
			// cfg needs only the low lane: all its bits sit in byte zero
			if (wr & hit_cfg) cfg_q <= DAT_I[2:0];
			// a refused start sets the flag; an accepted start clears it
			if (wr & hit_cmd) refused_q <= ~can_go;
		end
	end

	// ==========================================
	// pin sequencer
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			st_q <= S_IDLE;
			op_q <= OP_READ;
			idx_q <= 3'h0;
			cnt_q <= 5'h00;
			rd_q <= '0;
			FL_ADDR <= '0;
			FL_DQ_O <= '0;
			FL_DQ_OE <= 1'b0;
			FL_CE_N <= 1'b1;
			FL_OE_N <= 1'b1;
			FL_WE_N <= 1'b1;
		end else begin
			// counter parks at zero; each state but idle reloads it on entry
			cnt_q <= done ? cnt_q : cnt_q - 5'h01;
			case (st_q)
				S_IDLE: begin
					if (start) begin
						op_q <= DAT_I[2:0];
						idx_q <= 3'h0;
						// one extra setup cycle while the pins leave idle
						cnt_q <= CY_SU + 5'h01;
						st_q <= S_SETUP;
					end
				end
				S_SETUP: begin
					// address and data settle before the strobe
					FL_ADDR <= step_rd ? ua_q : cur[35:16];
					FL_DQ_O <= cur[15:0];
					FL_DQ_OE <= ~step_rd;
					FL_CE_N <= 1'b0;
					if (done) begin
						FL_OE_N <= ~step_rd;
						FL_WE_N <= step_rd;
						// a read strobe also covers the input filter latency
						cnt_q <= step_rd ? CY_ACC + SYNC_LAT : CY_WP;
						st_q <= S_STROBE;
					end
				end
				S_STROBE: begin
					if (done) begin
						FL_OE_N <= 1'b1;
						FL_WE_N <= 1'b1;
						// read data carries the timeout flag
						if (step_rd) rd_q <= dq_f;
						// give busy pin time to fall
						cnt_q <= (last & dev_alg) ? CY_BUSY : CY_REC;
						st_q <= S_RECOV;
					end
				end
				S_RECOV: begin
					// data held past the rising strobe
					if (done) begin
						if (last) begin
							// release the bus so the next read finds it free
							FL_CE_N <= 1'b1;
							FL_DQ_OE <= 1'b0;
							st_q <= S_IDLE;
						end else begin
							idx_q <= idx_q + 3'h1;
							cnt_q <= CY_SU;
							st_q <= S_SETUP;
						end
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================
	// static pins
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			FL_BYTE_N <= 1'b1;
			FL_RESET_N <= 1'b0;
			FL_HV_EN <= 1'b0;
		end else begin
			FL_BYTE_N <= ~cfg_q[CFG_BYTE];
			FL_RESET_N <= ~cfg_q[CFG_HWRST];
			// hardware reset wins over unprotect so the pin never gets both
			// unprotect only while requested
			FL_HV_EN <= cfg_q[CFG_HV] & ~cfg_q[CFG_HWRST];
		end
	end

	assign ACK_O = ack_q;
	assign DAT_O = dat_q;

endmodule : fcsm_host

// ==== sim/fcsm_monitor.sv ====
`timescale 1ns/1ps
// ==========
// flash pin and bus acknowledge checks
module fcsm_monitor (
	// bus
	input wire logic		CLK_SYS,
	input wire logic		RST,
	input wire logic		CYC_I,
	input wire logic		STB_I,
	input wire logic		ACK_O,
	// flash
	input wire logic [19:0]	FL_ADDR,
	input wire logic [15:0]	FL_DQ_O,
	input wire logic		FL_DQ_OE,
	input wire logic		FL_CE_N,
	input wire logic		FL_OE_N,
	input wire logic		FL_WE_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	sequence s_pulse; !FL_WE_N [*3] ##1 FL_WE_N; endsequence
	sequence s_hold; ($stable(FL_ADDR) && $stable(FL_DQ_O)) [*3]; endsequence
	a_write_qual: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
		else $error("bad write strobe");
	a_read_qual: assert property (!FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE)
		else $error("bad read strobe");
	a_idle_quiet: assert property (FL_CE_N |-> FL_WE_N && FL_OE_N)
		else $error("strobe while deselected");
	a_pulse_width: assert property ($fell(FL_WE_N) |-> s_pulse)
		else $error("write pulse width");
	a_addr_setup: assert property ($fell(FL_WE_N) |-> FL_ADDR == $past(FL_ADDR, 2))
		else $error("address setup");
	a_data_hold: assert property ($rose(FL_WE_N) |-> s_hold)
		else $error("address or data hold");
	a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("ack late");
	a_ack_single: assert property (ACK_O |=> !ACK_O)
		else $error("ack too long");
endmodule : fcsm_monitor
bind fcsm_host fcsm_monitor fcsm_monitor_inst (.CLK_SYS(CLK_SYS), .RST(RST), .CYC_I(CYC_I),
	.STB_I(STB_I), .ACK_O(ACK_O), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
	.FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N));

// ==== sim/fcsm_flash_model.sv ====
`timescale 1ns/1ps
// ==========
// flash device model
module fcsm_flash_model #(
	parameter logic [15:0]	MFR = 16'h0000, // arbitrary
	parameter logic [15:0]	DEV = 16'h0000, // arbitrary
	parameter logic [7:0]	PROT = 8'h02,
	parameter int			BUSY = 60
) (
	// pins
	input wire logic		clk,
	input wire logic [19:0]	addr,
	input wire logic [15:0]	dq_in,
	output logic [15:0]		dq_out,
	input wire logic		ce_n,
	input wire logic		oe_n,
	input wire logic		we_n,
	input wire logic		reset_n,
	input wire logic		hv_en,
	input wire logic		byte_n,
	input wire logic		vcc_ok,
	output logic			ready_busy_n
);
	import fcsm_pkg::*;
	logic [15:0]	mem [128];
	logic [15:0]	last = 16'h0000;
	logic [19:0]	la;
	logic [2:0]		st = 3'h0;
	logic			auto = 1'b0;
	int				busy = 0;
	wire			wr = !ce_n && !we_n && oe_n;
	wire [6:0]		ix = {la[19:17], la[3:0]};
	logic [15:0]	drv;
	// byte mode expects the unlock addresses doubled
	wire [19:0]		ua1 = byte_n ? UA1_W : {UA1_W[18:0], 1'b0};
	wire [19:0]		ua2 = byte_n ? UA2_W : {UA2_W[18:0], 1'b0};
	initial foreach (mem[i]) mem[i] = 16'hFFFF;
	// address at later fall, data at earlier rise
	always @(posedge wr) la = addr;
	always @(negedge wr) if (vcc_ok && reset_n && busy == 0) begin
		if (dq_in == C_RESET) begin
			st = 3'h0;
			auto = 1'b0;
		end else if (st == 3'h3) begin
			// locked sectors and zero bits stay
			if (hv_en || !PROT[la[19:17]]) mem[ix] = mem[ix] & dq_in;
			busy = BUSY;
			st = 3'h0;
		end else if (st == 3'h0 || st == 3'h4) begin
			st = (la == ua1 && dq_in == C_UNLK1) ? st + 3'h1 : 3'h0;
		end else if (st == 3'h1 || st == 3'h5) begin
			st = (la == ua2 && dq_in == C_UNLK2) ? st + 3'h1 : 3'h0;
		end else if (st == 3'h6 && la == ua1 && dq_in == C_CERASE) begin
			foreach (mem[i]) if (hv_en || !PROT[i[6:4]]) mem[i] = 16'hFFFF;
			busy = BUSY;
			st = 3'h0;
		end else begin
			auto = auto || (st == 3'h2 && la == ua1 && dq_in == C_AUTOSEL);
			st = (st != 3'h2 || la != ua1) ? 3'h0 :
				dq_in == C_PROG ? 3'h3 : dq_in == C_ESETUP ? 3'h4 : 3'h0;
		end
	end
	// busy until done or hardware reset
	always @(posedge clk) busy = (!reset_n || busy == 0) ? 0 : busy - 1;
	always @(negedge reset_n) begin
		st = 3'h0;
		auto = 1'b0;
	end
	assign ready_busy_n = busy == 0;
	always @* begin
		if (busy != 0) drv = {9'h000, busy[0], 6'h00};
		else if (auto && addr[7:0] == 8'h00) drv = MFR;
		else if (auto && addr[7:0] == 8'h01) drv = DEV;
		else if (auto && addr[7:0] == 8'h02) drv = {15'h0000, PROT[addr[19:17]]};
		else drv = mem[{addr[19:17], addr[3:0]}];
	end
	// released bus shows the inverse of the last driven word so stale data never matches
	always @* if (!ce_n && !oe_n) last = drv;
	assign dq_out = (ce_n || oe_n) ? ~last : drv;
endmodule : fcsm_flash_model

// ==== sim/tb_fcsm_host.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
	$display("[FAIL] %s exp %h seen %h", n, e, s); end end
module tb_fcsm_host;
	import fcsm_pkg::*;
	localparam logic [15:0] MFR = 16'h005A; // arbitrary
	localparam logic [15:0] DEV = 16'h00C3; // arbitrary
	// ==========
	// signals
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, vcc = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, dat_o;
	logic ack, dq_oe, ce_n, oe_n, we_n, rst_n, hv, rb_n, byte_n;
	logic [19:0] fa;
	logic [15:0] dq_o, fq;
	wire [15:0] dq = dq_oe ? dq_o : fq;
	int num_errors = 0, samples_checked = 0;
	always #12.5 clk = ~clk;
	fcsm_host fcsm_host_inst (.CLK_SYS(clk), .RST(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
		.ADR_I(adr), .SEL_I(4'hF), .DAT_I(wd), .DAT_O(dat_o), .ACK_O(ack), .FL_ADDR(fa),
		.FL_DQ_I(dq), .FL_DQ_O(dq_o), .FL_DQ_OE(dq_oe), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
		.FL_WE_N(we_n), .FL_BYTE_N(byte_n), .FL_RESET_N(rst_n), .FL_HV_EN(hv),
		.FL_READY_BUSY_N(rb_n), .VCC_OK(vcc));
	fcsm_flash_model #(.MFR(MFR), .DEV(DEV)) fcsm_flash_model_inst (.clk(clk), .addr(fa),
		.dq_in(dq), .dq_out(fq), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
		.hv_en(hv), .byte_n(byte_n), .vcc_ok(vcc), .ready_busy_n(rb_n));
	// ==========
	// bus tasks
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic idle(input logic [1:0] m);
		do wb(1'b0, REG_STATUS, 32'h0); while ((rd[1:0] & m) !== 2'b00);
	endtask : idle
	task automatic op(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d);
		wb(1'b1, REG_ADDR, {12'h000, a});
		wb(1'b1, REG_WDATA, {16'h0000, d});
		wb(1'b1, REG_CMD, {29'h0, o});
		idle(2'h3);
		wb(1'b0, REG_RDATA, 32'h0);
	endtask : op
	task automatic rchk(input string n, input logic [19:0] a, input logic [31:0] e);
		op(OP_READ, a, 16'h0);
		`CHK(n, e, rd)
	endtask : rchk
	// ==========
	// scenarios
	task automatic t_program();
		rchk("blank", 20'h00003, 32'hFFFF);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("tmo set", 1'b1, rd[4])
		op(OP_PROG, 20'h00003, 16'h1234);
		rchk("prog", 20'h00003, 32'h1234);
		op(OP_PROG, 20'h00003, 16'hFF0F);
		rchk("zero", 20'h00003, 32'h1204);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("tmo clear", 1'b0, rd[4])
		wb(1'b1, REG_CFG, 32'h1);
		op(OP_PROG, 20'h00005, 16'h00A5);
		wb(1'b1, REG_CFG, 32'h0);
		rchk("byte", 20'h00005, 32'h00A5);
	endtask : t_program
	task automatic t_auto();
		op(OP_AUTOSEL, 20'h00000, 16'h0);
		`CHK("mfr", {16'h0, MFR}, rd)
		rchk("dev", 20'h00001, {16'h0, DEV});
		rchk("locked", 20'h20002, 32'h1);
		rchk("open", 20'h40002, 32'h0);
		op(OP_RESET, 20'h7FFFF, 16'h0);
		rchk("exit", 20'h00003, 32'h1204);
	endtask : t_auto
	task automatic t_erase();
		op(OP_PROG, 20'h20003, 16'h00FF);
		rchk("lockprog", 20'h20003, 32'hFFFF);
		wb(1'b1, REG_CFG, 32'h2);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("hv", 1'b1, rd[5])
		op(OP_PROG, 20'h20003, 16'h00FF);
		wb(1'b1, REG_CFG, 32'h0);
		op(OP_CERASE, 20'h0, 16'h0);
		rchk("relock", 20'h20003, 32'h00FF);
		rchk("erased", 20'h00003, 32'hFFFF);
	endtask : t_erase
	task automatic t_abort();
		wb(1'b1, REG_CMD, {29'h0, OP_PROG});
		wb(1'b1, REG_CMD, {29'h0, OP_READ});
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("refused", 1'b1, rd[3])
		idle(2'h1);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("busy", 1'b1, rd[1])
		wb(1'b1, REG_CFG, 32'h4);
		repeat (10) @(posedge clk);
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("stopped", 1'b0, rd[1])
		wb(1'b1, REG_CFG, 32'h0);
		vcc <= 1'b0;
		repeat (10) @(posedge clk);
		wb(1'b1, REG_CMD, {29'h0, OP_READ});
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK("lockout", 2'h2, rd[3:2])
		vcc <= 1'b1;
		wb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask : t_abort
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		t_program();
		t_auto();
		t_erase();
		t_abort();
		wrap_up();
	end
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		wrap_up();
	end
endmodule : tb_fcsm_host
